// ---- hdl/pvt_pkg.sv ----
package pvt_pkg;

  // ****************************************************
  // level counters
  // ****************************************************
  localparam int LEVEL_W = 8;
  localparam int TIMER_W = 6;
  localparam logic [5:0] DECAY_RELOAD = 6'h28;
  localparam logic [5:0] DECAY_IDLE = 6'h01;
  localparam logic [3:0] FAST_ATTACK = 4'h4;
  localparam logic [3:0] FAST_DECAY = 4'h8;
  localparam logic [3:0] SLOW_ATTACK = 4'h2;
  localparam logic [3:0] SLOW_DECAY = 4'h1;
  localparam logic [7:0] PEAK_RESET = 8'hFF;
  localparam logic [7:0] VALLEY_RESET = 8'h00;

  // ****************************************************
  // symbol thresholds, in 256ths of the span
  // ****************************************************
  localparam logic [7:0] THR_LOW = 8'h32;
  localparam logic [7:0] THR_MID = 8'h86;
  localparam logic [7:0] THR_HIGH = 8'hD9;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_TIMERS = 8'h08;
  localparam int CTRL_FORCE_HOLD = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int ST_PEAK = 0;
  localparam int ST_VALLEY = 8;
  localparam int ST_MODE = 16;
  localparam int ST_INHIBIT = 18;
  localparam int ST_TEST = 19;
  localparam int ST_BW = 20;
  localparam int TM_PEAK = 0;
  localparam int TM_VALLEY = 8;

  typedef enum logic [1:0] {
    PVT_OFF,
    PVT_FAST,
    PVT_HOLD,
    PVT_SLOW
  } pvt_mode_t;

  typedef struct packed {
    logic bandwidth_select;
    logic mode_select_a;
    logic mode_select_b;
    logic track_inhibit;
    logic test_select;
  } pvt_ctrl_t;

endpackage : pvt_pkg

// ---- hdl/pvt_tracking_control.sv ----
// Behaviour
// [RQ1] control pins are captured on the falling edge of the symbol clock only
// [RQ2] mode pins decode to off, fast track, hold and slow track
// [RQ3] bandwidth pin low picks the 1 kHz cutoff, high the 2 kHz one
// [RQ4] track inhibit high blocks attack and decay enables of both counters
// [RQ5] track inhibit high leaves both counters as in hold
// [RQ6] fast track: peak up 4 on attack, down 8 on decay; valley mirrored
// [RQ7] slow track: peak up 2 per edge, down 1 per 40 edges; valley mirrored
// [RQ8] hold mode keeps both counters unchanged
// [RQ9] decay timer runs only when tracking; reload 1 after attack, 40 after decay
// [RQ10] peak is 8-bit; attacks when signal is above it, decays when below
// [RQ11] symbol code driven on two outputs, lsb and msb
// [RQ12] thresholds 50, 134, 217 of 256; codes 00, 10, 11, 01 going up
// [RQ13] symbol code keeps following the comparators while inhibit is high
// [RQ14] test mode treats the symbol clock as level sensitive
// [RQ15] far side supplies a steady 38.4 kHz square clock
// [RQ16] off mode raises the low power output
// [RQ17] attack wins over decay in the same step
// [RQ18] fast track holds the decay timer at 1
// [RQ19] off mode stops counters, timer forced to 1, values retained
// [RQ20] valley attacks down when signal is below, decays up when above
// [RQ21] counters saturate at 0 and 255
`timescale 1ns/1ps
`default_nettype none

module pvt_tracking_control #(
  parameter int LEVEL_W = pvt_pkg::LEVEL_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // pins from the protocol decoder
  input wire logic i_symbol_rate_clock,
  input wire logic i_bandwidth_select,
  input wire logic i_mode_select_a,
  input wire logic i_mode_select_b,
  input wire logic i_track_inhibit,
  input wire logic i_test_select,
  // filtered signal sample
  input wire logic [LEVEL_W-1:0] i_filtered_signal,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // converter outputs
  output logic o_symbol_code_msb,
  output logic o_symbol_code_lsb,
  output logic o_low_power,
  output logic o_bandwidth_2k,
  output logic [LEVEL_W-1:0] o_peak_level,
  output logic [LEVEL_W-1:0] o_valley_level
);

  // ****************************************************
  // elaboration checks
  // ****************************************************
  generate
    if (LEVEL_W != 8) begin : g_bad_level_w
      $error("pvt_tracking_control: LEVEL_W must be 8");
    end
    if (pvt_pkg::TIMER_W != 6) begin : g_bad_timer_w
      $error("pvt_tracking_control: decay timer must be 6 bits");
    end
  endgenerate

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [LEVEL_W-1:0] sat_step(input logic [LEVEL_W-1:0] val,
                                                  input logic up, input logic [3:0] amt);
    logic [LEVEL_W:0] wide;
    wide = '0;
    if (up) begin
      wide = {1'b0, val} + {{(LEVEL_W-3){1'b0}}, amt};
      sat_step = wide[LEVEL_W] ? {LEVEL_W{1'b1}} : wide[LEVEL_W-1:0]; // RQ21
    end else begin
      wide = {1'b0, val} - {{(LEVEL_W-3){1'b0}}, amt};
      sat_step = wide[LEVEL_W] ? {LEVEL_W{1'b0}} : wide[LEVEL_W-1:0]; // RQ21
    end
  endfunction : sat_step

  function automatic logic [LEVEL_W-1:0] thr(input logic [LEVEL_W-1:0] lo,
                                             input logic [LEVEL_W-1:0] hi,
                                             input logic [7:0] frac);
    logic [LEVEL_W+7:0] prod;
    prod = (hi >= lo) ? (LEVEL_W+8)'((hi - lo) * frac) : '0;
    thr = lo + prod[LEVEL_W+7:8]; // RQ12
  endfunction : thr

  function automatic pvt_pkg::pvt_mode_t decode_mode(input logic sel_a, input logic sel_b);
    case ({sel_a, sel_b})
      2'b00: decode_mode = pvt_pkg::PVT_OFF;
      2'b01: decode_mode = pvt_pkg::PVT_FAST;
      2'b10: decode_mode = pvt_pkg::PVT_HOLD;
      default: decode_mode = pvt_pkg::PVT_SLOW;
    endcase
  endfunction : decode_mode

  // ****************************************************
  // falling edge capture of the control pins
  // ****************************************************
  logic clk_q;
  logic fall;
  pvt_pkg::pvt_ctrl_t ctrl;
  pvt_pkg::pvt_mode_t mode;
  logic force_hold;

  assign fall = clk_q & ~i_symbol_rate_clock;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= i_symbol_rate_clock;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= '0;
    end else if (fall) begin
      ctrl <= '{i_bandwidth_select, i_mode_select_a, i_mode_select_b,
                i_track_inhibit, i_test_select}; // RQ1
    end
  end

  // ****************************************************
  // mode decode
  // ****************************************************
  assign mode = decode_mode(ctrl.mode_select_a, ctrl.mode_select_b); // RQ2

  // ****************************************************
  // step qualification
  // ****************************************************
  logic step;
  logic tracking;
  logic fast_mode;
  logic slow_mode;

  assign fast_mode = (mode == pvt_pkg::PVT_FAST);
  assign slow_mode = (mode == pvt_pkg::PVT_SLOW);

  // in test mode every system cycle with the symbol clock high is a step
  assign step = ctrl.test_select ? i_symbol_rate_clock : fall; // RQ14
  assign tracking = step & ~ctrl.track_inhibit & ~force_hold &
                    (fast_mode | slow_mode); // RQ4 RQ5 RQ8 RQ19

  // ****************************************************
  // peak (0) and valley (1) counters
  // ****************************************************
  localparam int CHANNELS = 2;

  logic [LEVEL_W-1:0] level [CHANNELS];
  logic [5:0] timer [CHANNELS];

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      localparam logic [LEVEL_W-1:0] INIT = (g == 0) ? pvt_pkg::PEAK_RESET : pvt_pkg::VALLEY_RESET;
      logic attack;
      logic decay;
      logic decay_en;
      logic [3:0] attack_amt;
      logic [3:0] decay_amt;
      logic [LEVEL_W-1:0] next_level;
      logic [5:0] next_timer;
      // peak attacks upward, valley attacks downward
      assign attack = (g == 0) ? (i_filtered_signal > level[g]) :
                                 (i_filtered_signal < level[g]); // RQ10 RQ20
      assign decay = (g == 0) ? (i_filtered_signal < level[g]) :
                                (i_filtered_signal > level[g]); // RQ10 RQ20
      assign decay_en = decay & (fast_mode || (timer[g] == pvt_pkg::DECAY_IDLE));

      assign attack_amt = fast_mode ? pvt_pkg::FAST_ATTACK : pvt_pkg::SLOW_ATTACK; // RQ6 RQ7
      assign decay_amt = fast_mode ? pvt_pkg::FAST_DECAY : pvt_pkg::SLOW_DECAY; // RQ6 RQ7

      // attack is tried first so it wins over a decay in the same step
      always_comb begin
        next_level = level[g];
        if (tracking) begin
          if (attack) begin // RQ17
            next_level = sat_step(level[g], g == 0, attack_amt);
          end else if (decay_en) begin
            next_level = sat_step(level[g], g != 0, decay_amt);
          end
        end
      end

      always_comb begin
        next_timer = timer[g];
        if (!slow_mode) begin
          next_timer = pvt_pkg::DECAY_IDLE; // RQ18 RQ19
        end else if (tracking) begin // RQ9
          if (attack) begin
            next_timer = pvt_pkg::DECAY_IDLE;
          end else if (decay_en) begin
            next_timer = pvt_pkg::DECAY_RELOAD;
          end else if (decay) begin
            next_timer = timer[g] - 6'h01;
          end
        end
      end

      always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          level[g] <= INIT;
        end else begin
          level[g] <= next_level;
        end
      end

      always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          timer[g] <= pvt_pkg::DECAY_IDLE;
        end else begin
          timer[g] <= next_timer;
        end
      end
    end
  endgenerate

  // ****************************************************
  // symbol code and pin outputs
  // ****************************************************
  logic [LEVEL_W-1:0] t_low;
  logic [LEVEL_W-1:0] t_mid;
  logic [LEVEL_W-1:0] t_high;
  logic above_low;
  logic above_mid;
  logic above_high;

  assign t_low = thr(level[1], level[0], pvt_pkg::THR_LOW);
  assign t_mid = thr(level[1], level[0], pvt_pkg::THR_MID);
  assign t_high = thr(level[1], level[0], pvt_pkg::THR_HIGH);

  assign above_low = (i_filtered_signal > t_low); // RQ12
  assign above_mid = (i_filtered_signal > t_mid); // RQ12
  assign above_high = (i_filtered_signal > t_high); // RQ12

  // updated every cycle regardless of track inhibit
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_symbol_code_msb <= 1'b0;
      o_symbol_code_lsb <= 1'b0;
    end else begin // RQ13
      o_symbol_code_msb <= above_low & ~above_high; // RQ11 RQ12
      o_symbol_code_lsb <= above_mid; // RQ11 RQ12
    end
  end

  // ****************************************************
  // pin outputs
  // ****************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_low_power <= 1'b1;
      o_bandwidth_2k <= 1'b0;
    end else begin
      o_low_power <= (mode == pvt_pkg::PVT_OFF); // RQ16
      o_bandwidth_2k <= ctrl.bandwidth_select; // RQ3
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_peak_level <= pvt_pkg::PEAK_RESET;
      o_valley_level <= pvt_pkg::VALLEY_RESET;
    end else begin
      o_peak_level <= level[0];
      o_valley_level <= level[1];
    end
  end

  // ****************************************************
  // wishbone registers
  // ****************************************************
  logic req;
  logic ctrl_wr;
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign ctrl_wr = req & i_wb_we & i_wb_sel[0] & (i_wb_adr == pvt_pkg::ADR_CTRL);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= req;
    end
  end

  // ****************************************************
  // control register
  // ****************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      force_hold <= pvt_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      force_hold <= i_wb_dat[pvt_pkg::CTRL_FORCE_HOLD];
    end
  end

  // ****************************************************
  // read data
  // ****************************************************
  logic [31:0] next_rd_dat;

  always_comb begin
    next_rd_dat = '0;
    case (i_wb_adr)
      pvt_pkg::ADR_CTRL: next_rd_dat[pvt_pkg::CTRL_FORCE_HOLD] = force_hold;
      pvt_pkg::ADR_STATUS: begin
        next_rd_dat[pvt_pkg::ST_PEAK +: 8] = level[0];
        next_rd_dat[pvt_pkg::ST_VALLEY +: 8] = level[1];
        next_rd_dat[pvt_pkg::ST_MODE +: 2] = mode;
        next_rd_dat[pvt_pkg::ST_INHIBIT] = ctrl.track_inhibit;
        next_rd_dat[pvt_pkg::ST_TEST] = ctrl.test_select;
        next_rd_dat[pvt_pkg::ST_BW] = ctrl.bandwidth_select;
      end
      pvt_pkg::ADR_TIMERS: begin
        next_rd_dat[pvt_pkg::TM_PEAK +: 6] = timer[0];
        next_rd_dat[pvt_pkg::TM_VALLEY +: 6] = timer[1];
      end
      default: next_rd_dat = '0;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_dat <= '0;
    end else if (req) begin
      o_wb_dat <= next_rd_dat;
    end
  end

endmodule : pvt_tracking_control

`default_nettype wire

// ---- tb/pvt_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module pvt_properties (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // pins and sample
  input wire logic i_symbol_rate_clock,
  input wire logic i_mode_select_a,
  input wire logic i_mode_select_b,
  input wire logic i_track_inhibit,
  input wire logic i_bandwidth_select,
  input wire logic i_test_select,
  input wire logic [7:0] i_filtered_signal,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  // outputs
  input wire logic o_wb_ack,
  input wire logic o_low_power,
  input wire logic o_bandwidth_2k,
  input wire logic [7:0] o_peak_level,
  input wire logic [7:0] o_valley_level
);
  logic sym_q;
  logic fall;
  logic [2:0] cap;
  logic tst;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);
  assign fall = sym_q && !i_symbol_rate_clock;
  // mode and inhibit in force for the next step
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sym_q <= 1'b1;
      cap <= 3'b000;
      tst <= 1'b0;
    end else begin
      sym_q <= i_symbol_rate_clock;
      if (fall) begin
        cap <= {i_mode_select_a, i_mode_select_b, i_track_inhibit};
        tst <= i_test_select;
      end
    end
  end
  off_power_a: assert property (
    fall && !i_mode_select_a && !i_mode_select_b |-> ##[1:2] o_low_power)
    else $error("low power not raised");
  bw_follow_a: assert property (
    fall && i_bandwidth_select |-> ##[1:2] o_bandwidth_2k) else $error("bandwidth not set");
  step_on_fall_a: assert property (
    $changed(o_peak_level) || $changed(o_valley_level) |->
    $past(tst, 2) || ($past(i_symbol_rate_clock, 3) && !$past(i_symbol_rate_clock, 2)))
    else $error("level moved off a falling edge");
  levels_held_a: assert property (
    fall && (cap[0] || !cap[1]) |=> ##1 $stable(o_peak_level) && $stable(o_valley_level))
    else $error("levels moved while held");
  fast_decay_a: assert property (
    fall && !tst && cap == 3'b010 && i_filtered_signal < o_peak_level && o_peak_level > 8'h07
    |=> ##1 o_peak_level == $past(o_peak_level, 2) - 8'h08) else $error("fast decay wrong");
  slow_attack_a: assert property (
    fall && !tst && cap == 3'b110 && i_filtered_signal < o_valley_level && o_valley_level > 8'h01
    |=> ##1 o_valley_level == $past(o_valley_level, 2) - 8'h02) else $error("slow attack wrong");
  floor_sat_a: assert property (
    o_valley_level < 8'h08 |=> o_valley_level < 8'h10) else $error("valley wrapped");
  ack_pulse_a: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack) else $error("ack wrong");
  cover property (fall && cap == 3'b010);
  cover property (fall && cap == 3'b110);
  cover property (o_low_power ##1 !o_low_power);
endmodule : pvt_properties
`default_nettype wire

// ---- tb/pvt_decoder_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pvt_decoder_model #(
  parameter int HALF = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire pvt_pkg::pvt_ctrl_t i_req,
  output logic o_sym_clk,
  output var pvt_pkg::pvt_ctrl_t o_pins
);
  int cnt;
  // free-running square clock; pins move only as it rises
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 0;
      o_sym_clk <= 1'b1;
      o_pins <= '0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      o_sym_clk <= !o_sym_clk;
      if (!o_sym_clk)
        o_pins <= i_req;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : pvt_decoder_model
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int HALF_SYM = 4;
  logic i_sys_clk, i_arst_n, i_symbol_rate_clock, i_bandwidth_select, i_test_select;
  logic i_mode_select_a, i_mode_select_b, i_track_inhibit;
  logic i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_low_power, o_bandwidth_2k;
  logic o_symbol_code_msb, o_symbol_code_lsb;
  logic [7:0] i_filtered_signal, i_wb_adr, o_peak_level, o_valley_level, p;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  pvt_pkg::pvt_ctrl_t req, pins;
  int k, fail_count = 0, n_compared = 0;
  logic [7:0] lvl [6] = '{8'h31, 8'h32, 8'h85, 8'h86, 8'hD8, 8'hD9};
  logic [1:0] code [6] = '{2'h0, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
  assign {i_bandwidth_select, i_mode_select_a, i_mode_select_b, i_track_inhibit,
    i_test_select} = pins;
  pvt_tracking_control dut_u (.*);
  pvt_decoder_model #(.HALF(HALF_SYM)) model_u (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
    .i_req(req), .o_sym_clk(i_symbol_rate_clock), .o_pins(pins));
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    k = 0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 20);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_sys_clk);
    if (k >= 20) begin
      fail_count++;
      end_sim();
    end
  endtask : wb
  task automatic setr(input logic [4:0] v, input int n);
    req <= v;
    repeat (n) @(posedge i_sys_clk);
  endtask : setr
  // wait for the next peak step, k counts the cycles
  task automatic wchg();
    p = o_peak_level;
    k = 0;
    while (o_peak_level === p && k < 2000) begin
      @(posedge i_sys_clk);
      k++;
    end
    if (k >= 2000) begin
      fail_count++;
      end_sim();
    end
  endtask : wchg
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fail_count++;
    end_sim();
  end
  initial begin
    i_arst_n = 1'b0;
    {i_wb_cyc, i_wb_stb, i_wb_we} = 3'b000;
    i_wb_adr = 8'h00;
    i_wb_dat = 32'h0;
    i_wb_sel = 4'hF;
    i_filtered_signal = 8'h00;
    req = '0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    @(posedge i_sys_clk);
    check("low_power", o_low_power, 1'b1);
    wb(1'b0, pvt_pkg::ADR_STATUS, 32'h0);
    check("status", q, 32'h0000_00FF);
    wb(1'b1, pvt_pkg::ADR_CTRL, 32'h1);
    wb(1'b0, pvt_pkg::ADR_CTRL, 32'h0);
    check("ctrl", q, 32'h1);
    wb(1'b1, pvt_pkg::ADR_CTRL, 32'h0);
    wb(1'b0, 8'h0C, 32'h0);
    check("unmapped", q, 32'h0);
    setr(5'b11010, 40);
    check("low_power", o_low_power, 1'b0);
    check("bw_2k", o_bandwidth_2k, 1'b1);
    for (int i = 0; i < 6; i++) begin
      i_filtered_signal <= lvl[i];
      repeat (3) @(posedge i_sys_clk);
      check("code", {o_symbol_code_msb, o_symbol_code_lsb}, code[i]);
    end
    i_filtered_signal <= 8'h80;
    setr(5'b00100, 1);
    wchg();
    check("fast_peak", o_peak_level, 8'hF7);
    check("fast_valley", o_valley_level, 8'h08);
    check("bw_1k", o_bandwidth_2k, 1'b0);
    setr(5'b00110, 24);
    p = o_peak_level;
    repeat (40) @(posedge i_sys_clk);
    check("inhibit_peak", o_peak_level, p);
    i_filtered_signal <= 8'h00;
    setr(5'b01100, 1);
    wchg();
    wchg();
    check("decay_gap", k, 40 * 2 * HALF_SYM);
    check("valley_floor", o_valley_level, 8'h00);
    setr(5'b00000, 40);
    check("off_power", o_low_power, 1'b1);
    p = o_peak_level;
    repeat (40) @(posedge i_sys_clk);
    check("off_peak", o_peak_level, p);
    // test mode, fast: a step on each of the 4 high cycles of every symbol period
    setr(5'b00101, 24);
    p = o_peak_level;
    repeat (8) @(posedge i_sys_clk);
    check("test_peak", o_peak_level, p - 4 * pvt_pkg::FAST_DECAY);
    end_sim();
  end
endmodule : tb_top
bind pvt_tracking_control pvt_properties prop_u (.*);
`default_nettype wire
